// ===== timer16_cfg.svh
// Offsets, field positions, reset values and timing constants of the PWM timer
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH

`define T16_OFF_CTRL    8'h00
`define T16_OFF_COUNT   8'h04
`define T16_OFF_CMP_A   8'h08
`define T16_OFF_CMP_B   8'h0c
`define T16_OFF_CAPT    8'h10
`define T16_OFF_FLAGS   8'h14
`define T16_OFF_PINDIR  8'h18

`define T16_CTRL_WGM_LSB  0
`define T16_CTRL_CS_LSB   4
`define T16_CTRL_OMA_LSB  8
`define T16_CTRL_OMB_LSB  10

`define T16_FLAG_OVF   0
`define T16_FLAG_CMPA  1
`define T16_FLAG_CMPB  2
`define T16_FLAG_CAPT  3

`define T16_RST_CTRL   32'h0000_0000
`define T16_RST_WORD   16'h0000

`define T16_WGM_PC8    4'h1
`define T16_WGM_PC9    4'h2
`define T16_WGM_PC10   4'h3
`define T16_WGM_FP8    4'h5
`define T16_WGM_FP9    4'h6
`define T16_WGM_FP10   4'h7
`define T16_WGM_PCCAP  4'ha
`define T16_WGM_PCCMP  4'hb
`define T16_WGM_FPCAP  4'he
`define T16_WGM_FPCMP  4'hf

`define T16_TOP_8      16'h00ff
`define T16_TOP_9      16'h01ff
`define T16_TOP_10     16'h03ff
`define T16_TOP_MAX    16'hffff

`define T16_OM_OFF     2'h0
`define T16_OM_TOGGLE  2'h1
`define T16_OM_NONINV  2'h2
`define T16_OM_INV     2'h3

`define T16_DIV_1      10'h000
`define T16_DIV_8      10'h007
`define T16_DIV_64     10'h03f
`define T16_DIV_256    10'h0ff
`define T16_DIV_1024   10'h3ff

`endif

// ===== timer16_pkg.sv
// Types shared by the PWM timer
package timer16_pkg;

  typedef enum logic [1:0]
  {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } dir_state_type;

  typedef struct packed
  {
    logic capture;
    logic cmp_b;
    logic cmp_a;
    logic overflow;
  } flags_type;

  typedef struct packed
  {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } apb_req_type;

endpackage

// ===== timer16_pwm.sv
// 16-bit timer with fast and phase-correct PWM behind an APB slave
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "timer16_cfg.svh"

module timer16_pwm #(
  parameter int CW = 16
) (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic      [1:0]        compare_output_pin_o,
  output logic      [1:0]        compare_output_oe_o
);

  logic                  rst_meta_ff;
  logic                  rst_n_ff;
  timer16_pkg::apb_req_type req;
  logic                  pready_ff;
  logic                  pslverr_ff;
  logic [31:0]           prdata_ff;
  logic                  access;
  logic                  wr_en;
  logic                  mapped;
  logic [31:0]           nxt_rdata;
  logic [3:0]            waveform_mode_field_ff;
  logic [2:0]            clk_sel_ff;
  logic [1:0][1:0]       output_mode_field_ff;
  logic [1:0]            pin_direction_bit_ff;
  logic [1:0][CW-1:0]    compare_reg_n_ff;
  logic [1:0][CW-1:0]    cmp_act_ff;
  logic [CW-1:0]         capture_reg_ff;
  logic [CW-1:0]         count_value_ff;
  timer16_pkg::dir_state_type dir_ff;
  timer16_pkg::flags_type flags_ff;
  timer16_pkg::flags_type flag_set;
  timer16_pkg::flags_type flag_clr;
  logic [1:0]            wave_ff;
  logic [1:0]            oe_ff;
  logic [9:0]            pre_cnt_ff;
  logic [9:0]            pre_div;
  logic                  tick;
  logic                  is_fast;
  logic                  is_phase;
  logic                  fixed_top;
  logic                  cap_top;
  logic                  cmp_top;
  logic [CW-1:0]         top_val;
  logic                  at_top;
  logic                  at_bottom_down;
  logic                  load_cmp;
  logic                  up_phase;
  logic [CW-1:0]         wmask;
  logic [1:0]            match;

  // Reset release through two flops
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // One driver for the whole request, fields in struct order
  assign req = {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i};

  // Waveform mode decode
  always_comb
  begin
    is_fast   = 1'b0;
    is_phase  = 1'b0;
    fixed_top = 1'b0;
    cap_top   = 1'b0;
    cmp_top   = 1'b0;
    top_val   = `T16_TOP_MAX;
    case (waveform_mode_field_ff)
      `T16_WGM_PC8, `T16_WGM_FP8:
      begin
        fixed_top = 1'b1;
        top_val   = `T16_TOP_8;
      end
      `T16_WGM_PC9, `T16_WGM_FP9:
      begin
        fixed_top = 1'b1;
        top_val   = `T16_TOP_9;
      end
      `T16_WGM_PC10, `T16_WGM_FP10:
      begin
        fixed_top = 1'b1;
        top_val   = `T16_TOP_10;
      end
      `T16_WGM_PCCAP, `T16_WGM_FPCAP:
      begin
        cap_top = 1'b1;
        top_val = capture_reg_ff;
      end
      `T16_WGM_PCCMP, `T16_WGM_FPCMP:
      begin
        cmp_top = 1'b1;
        top_val = cmp_act_ff[0];
      end
      default:
      begin
        top_val = `T16_TOP_MAX;
      end
    endcase
    case (waveform_mode_field_ff)
      `T16_WGM_FP8, `T16_WGM_FP9, `T16_WGM_FP10, `T16_WGM_FPCAP, `T16_WGM_FPCMP:
        is_fast = 1'b1;
      `T16_WGM_PC8, `T16_WGM_PC9, `T16_WGM_PC10, `T16_WGM_PCCAP, `T16_WGM_PCCMP:
        is_phase = 1'b1;
      default:
        is_fast = 1'b0;
    endcase
  end

  assign wmask          = fixed_top ? top_val : `T16_TOP_MAX;
  assign at_top         = (count_value_ff == top_val);
  assign at_bottom_down = (count_value_ff == '0) && (dir_ff == timer16_pkg::DIR_DOWN);
  assign up_phase       = (count_value_ff == '0) || ((dir_ff == timer16_pkg::DIR_UP) && !at_top);

  // Prescaler divide select
  always_comb
  begin
    case (clk_sel_ff)
      3'h1:    pre_div = `T16_DIV_1;
      3'h2:    pre_div = `T16_DIV_8;
      3'h3:    pre_div = `T16_DIV_64;
      3'h4:    pre_div = `T16_DIV_256;
      3'h5:    pre_div = `T16_DIV_1024;
      default: pre_div = `T16_DIV_1;
    endcase
  end

  assign tick = (clk_sel_ff != 3'h0) && (clk_sel_ff <= 3'h5) && (pre_cnt_ff >= pre_div);

  always_ff @(posedge sys_clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      pre_cnt_ff <= 10'h000;
    else if (tick || clk_sel_ff == 3'h0)
      pre_cnt_ff <= 10'h000;
    else
      pre_cnt_ff <= pre_cnt_ff + 10'h001;
  end

  // Buffer load point per mode
  always_comb
  begin
    if (is_fast)
      load_cmp = tick && at_top;
    else if (is_phase)
      load_cmp = tick && at_top && (dir_ff == timer16_pkg::DIR_UP);
    else
      load_cmp = 1'b1;
  end

  // Counter and direction
  always_ff @(posedge sys_clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      count_value_ff <= `T16_RST_WORD;
      dir_ff         <= timer16_pkg::DIR_UP;
    end
    else if (tick)
    begin
      case (dir_ff)
        timer16_pkg::DIR_UP:
        begin
          if (is_fast && at_top)
            count_value_ff <= '0;
          else if (is_phase && at_top)
          begin
            count_value_ff <= count_value_ff - 1'b1;
            dir_ff         <= timer16_pkg::DIR_DOWN;
          end
          else
            count_value_ff <= count_value_ff + 1'b1;
        end
        timer16_pkg::DIR_DOWN:
        begin
          if (!is_phase)
          begin
            count_value_ff <= count_value_ff + 1'b1;
            dir_ff         <= timer16_pkg::DIR_UP;
          end
          else if (count_value_ff == '0)
          begin
            count_value_ff <= count_value_ff + 1'b1;
            dir_ff         <= timer16_pkg::DIR_UP;
          end
          else
            count_value_ff <= count_value_ff - 1'b1;
        end
        default:
        begin
          count_value_ff <= '0;
          dir_ff         <= timer16_pkg::DIR_UP;
        end
      endcase
    end
  end

  // Active compare values
  always_ff @(posedge sys_clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      cmp_act_ff <= '0;
    else if (load_cmp)
      cmp_act_ff <= compare_reg_n_ff;
  end

  // Flag events
  always_comb
  begin
    match[0]          = tick && (count_value_ff == cmp_act_ff[0]);
    match[1]          = tick && (count_value_ff == cmp_act_ff[1]);
    flag_set          = '0;
    flag_set.cmp_a    = match[0];
    flag_set.cmp_b    = match[1];
    if (is_fast)
    begin
      flag_set.overflow = tick && at_top;
      flag_set.capture  = tick && at_top && cap_top;
      flag_set.cmp_a    = match[0] || (tick && at_top && cmp_top);
    end
    else if (is_phase)
    begin
      flag_set.overflow = tick && at_bottom_down;
      flag_set.capture  = load_cmp && cap_top;
      flag_set.cmp_a    = match[0] || (load_cmp && cmp_top);
    end
    else
      flag_set.overflow = tick && (count_value_ff == `T16_TOP_MAX);
  end

  assign flag_clr = (wr_en && req.addr == `T16_OFF_FLAGS) ? req.wdata[3:0] : 4'h0;

  // Write one to clear; a same-cycle event wins
  always_ff @(posedge sys_clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      flags_ff <= '0;
    else
      flags_ff <= (flags_ff & ~flag_clr) | flag_set;
  end

  // Waveform per compare channel
  for (genvar gi = 0; gi < 2; gi++)
  begin : g_wave
    logic toggle_ok;
    assign toggle_ok = (gi == 0) && (waveform_mode_field_ff == `T16_WGM_FPCMP
                                  || waveform_mode_field_ff == `T16_WGM_PCCMP);

    always_ff @(posedge sys_clk_i or negedge rst_n_ff)
    begin
      if (!rst_n_ff)
        wave_ff[gi] <= 1'b0;
      else
      begin
        case (output_mode_field_ff[gi])
          `T16_OM_TOGGLE:
          begin
            if (match[gi] && (toggle_ok || (!is_fast && !is_phase)))
              wave_ff[gi] <= ~wave_ff[gi];
          end
          `T16_OM_NONINV, `T16_OM_INV:
          begin
            if (is_fast)
            begin
              if (tick && at_top)
                wave_ff[gi] <= (output_mode_field_ff[gi] == `T16_OM_INV);
              else if (match[gi])
                wave_ff[gi] <= (output_mode_field_ff[gi] == `T16_OM_NONINV);
            end
            else if (is_phase)
            begin
              if (match[gi])
                wave_ff[gi] <= up_phase ^ (output_mode_field_ff[gi] == `T16_OM_NONINV);
            end
            else if (match[gi])
              wave_ff[gi] <= (output_mode_field_ff[gi] == `T16_OM_INV);
          end
          default:
            wave_ff[gi] <= 1'b0;
        endcase
      end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_ff)
    begin
      if (!rst_n_ff)
        oe_ff[gi] <= 1'b0;
      else
        oe_ff[gi] <= pin_direction_bit_ff[gi] && (output_mode_field_ff[gi] != `T16_OM_OFF);
    end
  end

  assign compare_output_pin_o = wave_ff;
  assign compare_output_oe_o  = oe_ff;

  // APB slave
  assign access = req.sel && req.enable;
  assign wr_en  = access && pready_ff && req.write;

  always_comb
  begin
    mapped = 1'b1;
    case (req.addr)
      `T16_OFF_CTRL:
        nxt_rdata = {20'h0, output_mode_field_ff, 1'b0, clk_sel_ff, waveform_mode_field_ff};
      `T16_OFF_COUNT:  nxt_rdata = {16'h0, count_value_ff};
      `T16_OFF_CMP_A:  nxt_rdata = {16'h0, compare_reg_n_ff[0]};
      `T16_OFF_CMP_B:  nxt_rdata = {16'h0, compare_reg_n_ff[1]};
      `T16_OFF_CAPT:   nxt_rdata = {16'h0, capture_reg_ff};
      `T16_OFF_FLAGS:  nxt_rdata = {28'h0, flags_ff};
      `T16_OFF_PINDIR: nxt_rdata = {30'h0, pin_direction_bit_ff};
      default:
      begin
        nxt_rdata = 32'h0000_0000;
        mapped    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff  <= access && !pready_ff;
      pslverr_ff <= access && !pready_ff && !mapped;
      if (access && !pready_ff && !req.write)
        prdata_ff <= nxt_rdata;
    end
  end

  assign prdata_o  = prdata_ff;
  assign pready_o  = pready_ff;
  assign pslverr_o = pslverr_ff;

  // Control registers
  always_ff @(posedge sys_clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      waveform_mode_field_ff <= 4'h0;
      clk_sel_ff             <= 3'h0;
      output_mode_field_ff   <= '0;
      pin_direction_bit_ff   <= 2'h0;
    end
    else if (wr_en && req.addr == `T16_OFF_CTRL)
    begin
      waveform_mode_field_ff  <= req.wdata[`T16_CTRL_WGM_LSB +: 4];
      clk_sel_ff              <= req.wdata[`T16_CTRL_CS_LSB +: 3];
      output_mode_field_ff[0] <= req.wdata[`T16_CTRL_OMA_LSB +: 2];
      output_mode_field_ff[1] <= req.wdata[`T16_CTRL_OMB_LSB +: 2];
    end
    else if (wr_en && req.addr == `T16_OFF_PINDIR)
      pin_direction_bit_ff <= req.wdata[1:0];
  end

  // Compare buffers and capture register
  always_ff @(posedge sys_clk_i or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      compare_reg_n_ff <= '0;
      capture_reg_ff   <= `T16_RST_WORD;
    end
    else if (wr_en)
    begin
      if (req.addr == `T16_OFF_CMP_A)
        compare_reg_n_ff[0] <= req.wdata[CW-1:0] & wmask;
      if (req.addr == `T16_OFF_CMP_B)
        compare_reg_n_ff[1] <= req.wdata[CW-1:0] & wmask;
      if (req.addr == `T16_OFF_CAPT)
        capture_reg_ff <= req.wdata[CW-1:0];
    end
  end

endmodule

// ===== timer16_pwm_props.sv
// Port checks for the PWM timer, bound to its top module
`timescale 1ns/10ps
`include "timer16_cfg.svh"
module timer16_pwm_props (
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [1:0]  compare_output_pin_o,
  input wire logic [1:0]  compare_output_oe_o
);
  logic [31:0] ctrl_ff;
  logic [1:0]  dir_ff;
  logic [3:0]  age_ff;
  logic        done_wr;
  logic        cfg_wr;
  assign done_wr = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
  assign cfg_wr  = done_wr && (paddr_i == `T16_OFF_CTRL || paddr_i == `T16_OFF_PINDIR);
  // Shadow of control and direction, with cycles since last change
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_ff <= 32'h0000_0000;
      dir_ff  <= 2'h0;
      age_ff  <= 4'h0;
    end
    else
    begin
      if (done_wr && paddr_i == `T16_OFF_CTRL)
        ctrl_ff <= pwdata_i;
      if (done_wr && paddr_i == `T16_OFF_PINDIR)
        dir_ff <= pwdata_i[1:0];
      if (cfg_wr)
        age_ff <= 4'h0;
      else if (age_ff != 4'hf)
        age_ff <= age_ff + 4'h1;
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_ready_wait: assert property ((psel_i && penable_i && !pready_o) |=> pready_o)
    else $error("access not answered after one wait state");
  a_err_with_ready: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
    else $error("error outside completion");
  a_err_read_zero: assert property ((pslverr_o && !pwrite_i) |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($rose(reset_n_i) |-> compare_output_oe_o == 2'h0 ##1 !pready_o)
    else $error("outputs active right after reset");
  a_oe_follows_cfg: assert property ((age_ff >= 4'h3)
    |-> compare_output_oe_o[0] == (dir_ff[0] && ctrl_ff[9:8] != 2'h0))
    else $error("pin enable disagrees with direction and mode");
  a_stop_freeze: assert property ((age_ff >= 4'h3 && ctrl_ff[6:4] == 3'h0) |-> $stable(compare_output_pin_o))
    else $error("pin moved with timer stopped");
  a_div8_spacing: assert property ((age_ff >= 4'h3 && ctrl_ff[6:4] == 3'h2
    && $changed(compare_output_pin_o[0])) |=> $stable(compare_output_pin_o[0])[*7])
    else $error("pin moved between divided ticks");
endmodule
bind timer16_pwm timer16_pwm_props chk_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .compare_output_pin_o(compare_output_pin_o),
  .compare_output_oe_o(compare_output_oe_o));

// ===== pin_load_model.sv
// Load on the compare output pins, pulled low when not driven
`timescale 1ns/10ps
module pin_load_model (
  input  wire logic [1:0] pin_i,
  input  wire logic [1:0] oe_i,
  output logic      [1:0] pad_o
);
  // Undriven pad sits at the pull-down level
  assign pad_o = pin_i & oe_i;
endmodule

// ===== tb.sv
// Self-checking bench for the PWM timer
`timescale 1ns/10ps
`include "timer16_cfg.svh"
module tb;
  logic        sys_clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  pin;
  logic [1:0]  oe;
  logic [1:0]  pad;
  int          fail_count;
  int          comparisons;
  int          cycles;
  timer16_pwm dut_u (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .compare_output_pin_o(pin), .compare_output_oe_o(oe));
  pin_load_model pad_u (.pin_i(pin), .oe_i(oe), .pad_o(pad));
  always #12.5 sys_clk = ~sys_clk;
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      fail_count++;
      finish_test;
    end
  end
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task do_reset;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
  // One APB transfer; holds the request until ready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic exp_e);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(nm, q, exp);
    check({nm, " err"}, {31'h0, e}, {31'h0, exp_e});
  endtask
  task setup(input logic [3:0] w, input logic [2:0] cs, input logic [1:0] om, input logic [15:0] cmp,
             input logic [15:0] cap, input logic [1:0] dir);
    do_reset;
    wr(`T16_OFF_CMP_A, {16'h0, cmp}); // Lands at once while no PWM mode is selected, so top is never zero
    wr(`T16_OFF_CTRL, {22'h0, om, 1'b0, 3'h0, w});
    wr(`T16_OFF_CAPT, {16'h0, cap});
    wr(`T16_OFF_PINDIR, {30'h0, dir});
    wr(`T16_OFF_CTRL, {22'h0, om, 1'b0, cs, w});
  endtask
  // Counts high cycles of pad A over one window after settling
  task duty(input logic [3:0] w, input logic [2:0] cs, input logic [1:0] om, input logic [15:0] cmp,
            input logic [15:0] cap, input int win, input int exp);
    int hi;
    setup(w, cs, om, cmp, cap, 2'h1);
    repeat (2 * win + 16) @(posedge sys_clk);
    hi = 0;
    repeat (win)
    begin
      @(posedge sys_clk);
      if (pad[0] === 1'b1)
        hi++;
    end
    check("pin A high cycles", 32'(hi), 32'(exp));
  endtask
  task scen_regs;
    logic [3:0] modes [3];
    logic [15:0] tops [3];
    modes = '{`T16_WGM_FP8, `T16_WGM_FP9, `T16_WGM_FP10};
    tops = '{`T16_TOP_8, `T16_TOP_9, `T16_TOP_10};
    do_reset;
    rd("ctrl reset", `T16_OFF_CTRL, `T16_RST_CTRL, 1'b0);
    rd("count reset", `T16_OFF_COUNT, 32'h0, 1'b0);
    rd("unmapped", 8'h1c, 32'h0, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      wr(`T16_OFF_CTRL, {28'h0, modes[i]});
      wr(`T16_OFF_CMP_B, 32'h0000_ffff);
      rd("masked compare", `T16_OFF_CMP_B, {16'h0, tops[i]}, 1'b0);
    end
  endtask
  task scen_pins;
    setup(`T16_WGM_FP8, 3'h1, `T16_OM_INV, 16'h00ff, 16'h0, 2'h0);
    repeat (600) @(posedge sys_clk);
    check("pad undriven", {30'h0, pad}, 32'h0);
    wr(`T16_OFF_PINDIR, 32'h1);
    repeat (4) @(posedge sys_clk);
    check("pad driven", {30'h0, pad}, 32'h1);
  endtask
  task flags(input logic [3:0] w, input logic [15:0] cmp, input logic [15:0] cap, input logic [31:0] exp);
    setup(w, 3'h1, `T16_OM_OFF, cmp, cap, 2'h0);
    repeat (300) @(posedge sys_clk);
    rd("flags", `T16_OFF_FLAGS, exp, 1'b0);
  endtask
  task scen_flags;
    flags(`T16_WGM_FPCMP, 16'h000f, 16'h0, 32'h7);
    flags(`T16_WGM_FPCAP, 16'h0000, 16'h003f, 32'hf);
    flags(`T16_WGM_PCCMP, 16'h0010, 16'h0, 32'h7);
    wr(`T16_OFF_CTRL, {28'h0, `T16_WGM_FPCAP});
    wr(`T16_OFF_FLAGS, 32'hf);
    rd("flags cleared", `T16_OFF_FLAGS, 32'h0, 1'b0);
  endtask
  task scen_fast;
    duty(`T16_WGM_FP8, 3'h1, `T16_OM_NONINV, 16'h0080, 16'h0, 256, 127);
    duty(`T16_WGM_FP8, 3'h1, `T16_OM_INV, 16'h0080, 16'h0, 256, 129);
    duty(`T16_WGM_FP8, 3'h1, `T16_OM_NONINV, 16'h0000, 16'h0, 256, 255);
    duty(`T16_WGM_FP8, 3'h1, `T16_OM_NONINV, 16'h00ff, 16'h0, 256, 0);
    duty(`T16_WGM_FP8, 3'h1, `T16_OM_INV, 16'h00ff, 16'h0, 256, 256);
    duty(`T16_WGM_FP8, 3'h2, `T16_OM_NONINV, 16'h0080, 16'h0, 2048, 1016);
    duty(`T16_WGM_FP9, 3'h1, `T16_OM_NONINV, 16'h0100, 16'h0, 512, 255);
    duty(`T16_WGM_FPCMP, 3'h1, `T16_OM_TOGGLE, 16'h000f, 16'h0, 256, 128);
    duty(`T16_WGM_FPCAP, 3'h1, `T16_OM_NONINV, 16'h0020, 16'h003f, 64, 31);
    duty(`T16_WGM_FPCAP, 3'h3, `T16_OM_NONINV, 16'h0001, 16'h0003, 256, 128);
    duty(`T16_WGM_FPCAP, 3'h4, `T16_OM_NONINV, 16'h0001, 16'h0003, 1024, 512);
    duty(`T16_WGM_FPCAP, 3'h5, `T16_OM_NONINV, 16'h0001, 16'h0003, 4096, 2048);
  endtask
  task scen_phase;
    duty(`T16_WGM_PC8, 3'h1, `T16_OM_NONINV, 16'h0040, 16'h0, 510, 128);
    duty(`T16_WGM_PC8, 3'h1, `T16_OM_INV, 16'h0040, 16'h0, 510, 382);
    duty(`T16_WGM_PC8, 3'h1, `T16_OM_NONINV, 16'h0000, 16'h0, 510, 0);
    duty(`T16_WGM_PC8, 3'h1, `T16_OM_NONINV, 16'h00ff, 16'h0, 510, 510);
    duty(`T16_WGM_PC10, 3'h1, `T16_OM_NONINV, 16'h0100, 16'h0, 2046, 512);
    duty(`T16_WGM_PCCMP, 3'h1, `T16_OM_TOGGLE, 16'h0010, 16'h0, 64, 32);
    duty(`T16_WGM_PCCAP, 3'h1, `T16_OM_NONINV, 16'h0020, 16'h0040, 128, 64);
  endtask
  initial
  begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_count = 0;
    comparisons = 0;
    cycles = 0;
    scen_regs;
    scen_pins;
    scen_flags;
    scen_fast;
    scen_phase;
    finish_test;
  end
endmodule
